// file: hdl/bit_assist_pkg.sv
// shared constants and carriers for the serial bit assist block
package bit_assist_pkg;
   // ------------------------------------------------------------
   // register byte addresses
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_DATA_PAD = 8'h00;
   localparam logic [7:0] ADDR_CLOCK_PAD = 8'h04;
   localparam logic [7:0] ADDR_CTRL = 8'h08;
   localparam logic [7:0] ADDR_FALL_COND = 8'h0C;
   localparam logic [7:0] ADDR_RISE_COND = 8'h10;
   localparam logic [7:0] ADDR_SAMPLED = 8'h14;
   localparam logic [7:0] ADDR_NEW_SAMPLE = 8'h18;
   localparam logic [7:0] ADDR_PULLUP = 8'h1C;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h20;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h24;
   localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h28;
   // ------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_STRETCH_BIT = 1;
   localparam int CTRL_COND_STRETCH_BIT = 2;
   localparam int CTRL_ACTIVE_BIT = 3;
   localparam int PULLUP_CLOCK_BIT = 4;
   localparam int PULLUP_DATA_BIT = 5;
   localparam int IRQ_FALL_BIT = 0;
   localparam int IRQ_RISE_BIT = 1;
   localparam int IRQ_SAMPLE_BIT = 2;
   localparam int IRQ_WIDTH = 3;
   localparam logic PAD_DRIVE_RESET = 1'b1;
   localparam logic [7:0] PULLUP_RESET = 8'h00;
   localparam int SYNC_STAGES = 3;

   typedef struct packed {
      logic clock_level;
      logic data_level;
   } line_levels_s;

   typedef struct packed {
      logic link_enable;
      logic stretch_enable;
      logic cond_stretch_enable;
   } link_ctrl_s;
endpackage : bit_assist_pkg

// file: hdl/pad_sync.sv
// three-stage synchroniser that only accepts a level once stages two and three agree
`timescale 1ns/1ps
module pad_sync #(
   parameter int STAGES = 3
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic raw_in,
   output logic level_q
);
   logic [STAGES-1:0] chain_q;

   initial begin
      if (STAGES != 3) begin
         $error("pad_sync needs exactly three stages");
      end
   end

   // idle lines are pulled high, so reset to released level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chain_q <= '1;
         level_q <= 1'b1;
      end else if (ce) begin
         chain_q <= {chain_q[STAGES-2:0], raw_in};
         if (chain_q[1] == chain_q[2]) begin
            level_q <= chain_q[2];
         end
      end
   end
endmodule : pad_sync

// file: hdl/line_edges.sv
// edge and start/stop condition finder on synchronised line levels
`timescale 1ns/1ps
module line_edges
   import bit_assist_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire line_levels_s lines,
   output logic clock_rise,
   output logic clock_fall,
   output logic data_fall_clk_high,
   output logic data_rise_clk_high
);
   line_levels_s prev_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_q <= '{clock_level: 1'b1, data_level: 1'b1};
      end else if (ce) begin
         prev_q <= lines;
      end
   end

   assign clock_rise = ce & lines.clock_level & ~prev_q.clock_level;
   assign clock_fall = ce & ~lines.clock_level & prev_q.clock_level;
   // clock must be high both before and after the data change
   assign data_fall_clk_high = ce & lines.clock_level & prev_q.clock_level
      & prev_q.data_level & ~lines.data_level;
   assign data_rise_clk_high = ce & lines.clock_level & prev_q.clock_level
      & ~prev_q.data_level & lines.data_level;
endmodule : line_edges

// file: hdl/bit_assist.sv
// serial bit assist: open-drain line control, conditions, stretching, sampling
`timescale 1ns/1ps
// Behaviour
// - enable hands both pads to block
// - pads open-drain while enabled
// - internal pull-ups from pull-up bits
// - stretch clock low after falling edge
// - stretch_active set while forcing low
// - sampled_data_reg write releases clock
// - conditional stretch needs prior fall condition
// - data captured on clock rising edge
// - new_sample_flag set on that edge
// - reading sampled_data_reg clears new flag
// - conditions shown as irq and flags
// - data falls, clock high sets flag
// - data rises, clock high sets flag
// - condition flags cleared by any write to them
// - pad reads return real pad levels
module bit_assist
   import bit_assist_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic clock_pad_in,
   output logic clock_pad_out,
   output logic clock_pad_oe_n,
   input wire logic data_pad_in,
   output logic data_pad_out,
   output logic data_pad_oe_n,
   output logic clock_pullup_en,
   output logic data_pullup_en,
   output logic fall_cond_irq,
   output logic rise_cond_irq,
   output logic irq
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   link_ctrl_s ctrl_q;
   logic clock_drive_q;
   logic data_drive_q;
   logic stretch_active_q;
   logic fall_cond_flag_q;
   logic rise_cond_flag_q;
   logic sampled_data_bit_q;
   logic new_sample_flag_q;
   logic [7:0] pullup_q;
   logic [IRQ_WIDTH-1:0] irq_status_q;
   logic [IRQ_WIDTH-1:0] irq_enable_q;
   line_levels_s lines;
   // each synchroniser drives its own net, so the struct has one driver
   logic clock_level_sync;
   logic data_level_sync;
   logic clock_rise;
   logic clock_fall;
   logic data_fall_clk_high;
   logic data_rise_clk_high;

   // ------------------------------------------------------------
   // pad synchronisers
   // ------------------------------------------------------------
   pad_sync #(.STAGES(SYNC_STAGES)) u_clock_sync (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .raw_in(clock_pad_in),
      .level_q(clock_level_sync)
   );

   pad_sync #(.STAGES(SYNC_STAGES)) u_data_sync (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .raw_in(data_pad_in),
      .level_q(data_level_sync)
   );

   assign lines = '{clock_level: clock_level_sync, data_level: data_level_sync};

   line_edges u_edges (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .lines(lines),
      .clock_rise(clock_rise),
      .clock_fall(clock_fall),
      .data_fall_clk_high(data_fall_clk_high),
      .data_rise_clk_high(data_rise_clk_high)
   );

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   wire logic access = psel & penable & ce;
   wire logic wr = access & pwrite;
   wire logic rd = access & ~pwrite;
   wire logic hit_data_pad = (paddr == ADDR_DATA_PAD);
   wire logic hit_clock_pad = (paddr == ADDR_CLOCK_PAD);
   wire logic hit_ctrl = (paddr == ADDR_CTRL);
   wire logic hit_fall = (paddr == ADDR_FALL_COND);
   wire logic hit_rise = (paddr == ADDR_RISE_COND);
   wire logic hit_sampled = (paddr == ADDR_SAMPLED);
   wire logic hit_new = (paddr == ADDR_NEW_SAMPLE);
   wire logic hit_pullup = (paddr == ADDR_PULLUP);
   wire logic hit_status = (paddr == ADDR_IRQ_STATUS);
   wire logic hit_enable = (paddr == ADDR_IRQ_ENABLE);
   wire logic hit_clear = (paddr == ADDR_IRQ_CLEAR);
   wire logic mapped = hit_data_pad | hit_clock_pad | hit_ctrl | hit_fall | hit_rise
      | hit_sampled | hit_new | hit_pullup | hit_status | hit_enable | hit_clear;

   // ------------------------------------------------------------
   // line events
   // ------------------------------------------------------------
   wire logic en = ctrl_q.link_enable;
   wire logic fall_event = en & data_fall_clk_high;
   wire logic rise_event = en & data_rise_clk_high;
   wire logic sample_event = en & clock_rise;
   wire logic release_wr = wr & hit_sampled;
   // flag state before this edge decides, so a same-cycle condition waits
   wire logic want_stretch = en & clock_fall
      & (ctrl_q.stretch_enable | (ctrl_q.cond_stretch_enable & fall_cond_flag_q));

   logic [31:0] rdata_d;
   assign rdata_d =
      hit_data_pad ? {31'h0, lines.data_level} :
      hit_clock_pad ? {31'h0, lines.clock_level} :
      hit_ctrl ? {28'h0, stretch_active_q, ctrl_q.cond_stretch_enable,
         ctrl_q.stretch_enable, ctrl_q.link_enable} :
      hit_fall ? {31'h0, fall_cond_flag_q} :
      hit_rise ? {31'h0, rise_cond_flag_q} :
      hit_sampled ? {31'h0, sampled_data_bit_q} :
      hit_new ? {31'h0, new_sample_flag_q} :
      hit_pullup ? {24'h0, pullup_q} :
      hit_status ? {29'h0, irq_status_q} :
      hit_enable ? {29'h0, irq_enable_q} :
      32'h0;

   // ------------------------------------------------------------
   // apb slave: no wait state (setup, then pready with data in the first access cycle)
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else if (ce) begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
         prdata <= (psel & ~penable & ~pwrite) ? rdata_d : 32'h0;
      end
   end

   // writes and reads take effect on the access edge where pready is high
   wire logic done_wr = wr & pready;
   wire logic done_rd = rd & pready;

   // ------------------------------------------------------------
   // control and drive registers
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= '0;
         clock_drive_q <= PAD_DRIVE_RESET;
         data_drive_q <= PAD_DRIVE_RESET;
         pullup_q <= PULLUP_RESET;
         irq_enable_q <= '0;
      end else if (ce && done_wr) begin
         if (hit_ctrl) begin
            ctrl_q.link_enable <= pwdata[CTRL_ENABLE_BIT];
            ctrl_q.stretch_enable <= pwdata[CTRL_STRETCH_BIT];
            ctrl_q.cond_stretch_enable <= pwdata[CTRL_COND_STRETCH_BIT];
         end else if (hit_data_pad) begin
            data_drive_q <= pwdata[0];
         end else if (hit_clock_pad) begin
            clock_drive_q <= pwdata[0];
         end else if (hit_pullup) begin
            pullup_q <= pwdata[7:0];
         end else if (hit_enable) begin
            irq_enable_q <= pwdata[IRQ_WIDTH-1:0];
         end
      end
   end

   // ------------------------------------------------------------
   // stretch, conditions, sample; hardware set beats clear
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stretch_active_q <= 1'b0;
         fall_cond_flag_q <= 1'b0;
         rise_cond_flag_q <= 1'b0;
         sampled_data_bit_q <= 1'b0;
         new_sample_flag_q <= 1'b0;
      end else if (ce) begin
         if (want_stretch) begin
            stretch_active_q <= 1'b1;
         end else if ((release_wr && pready) || !en) begin
            stretch_active_q <= 1'b0;
         end
         if (fall_event) begin
            fall_cond_flag_q <= 1'b1;
         end else if (done_wr && hit_fall) begin
            fall_cond_flag_q <= 1'b0;
         end
         if (rise_event) begin
            rise_cond_flag_q <= 1'b1;
         end else if (done_wr && hit_rise) begin
            rise_cond_flag_q <= 1'b0;
         end
         if (sample_event) begin
            sampled_data_bit_q <= lines.data_level;
            new_sample_flag_q <= 1'b1;
         end else if (done_rd && hit_sampled) begin
            new_sample_flag_q <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // interrupt status, enable, write-one-to-clear
   // ------------------------------------------------------------
   logic [IRQ_WIDTH-1:0] irq_set;
   assign irq_set = {sample_event, rise_event, fall_event};
   logic [IRQ_WIDTH-1:0] irq_clr;
   assign irq_clr = (done_wr && hit_clear) ? pwdata[IRQ_WIDTH-1:0] : '0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status_q <= '0;
         irq <= 1'b0;
         fall_cond_irq <= 1'b0;
         rise_cond_irq <= 1'b0;
      end else if (ce) begin
         irq_status_q <= irq_set | (irq_status_q & ~irq_clr);
         irq <= |((irq_set | (irq_status_q & ~irq_clr)) & irq_enable_q);
         fall_cond_irq <= fall_event;
         rise_cond_irq <= rise_event;
      end
   end

   // ------------------------------------------------------------
   // pad drivers: open drain, oe_n low only when pulling low
   // ------------------------------------------------------------
   wire logic clock_low = en & (~clock_drive_q | want_stretch | stretch_active_q);
   wire logic data_low = en & ~data_drive_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clock_pad_out <= 1'b0;
         data_pad_out <= 1'b0;
         clock_pad_oe_n <= 1'b1;
         data_pad_oe_n <= 1'b1;
         clock_pullup_en <= 1'b0;
         data_pullup_en <= 1'b0;
      end else if (ce) begin
         clock_pad_out <= 1'b0;
         data_pad_out <= 1'b0;
         clock_pad_oe_n <= ~(clock_low && !(release_wr && pready && !want_stretch)
            || (!clock_drive_q && en));
         data_pad_oe_n <= ~data_low;
         clock_pullup_en <= pullup_q[PULLUP_CLOCK_BIT];
         data_pullup_en <= pullup_q[PULLUP_DATA_BIT];
      end
   end
endmodule : bit_assist

// file: verif/bit_assist_props.sv
// checker for bus answers, open-drain pads and condition pulses
`timescale 1ns/1ps
module bit_assist_props
   import bit_assist_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic clock_pad_out,
   input wire logic clock_pad_oe_n,
   input wire logic data_pad_out,
   input wire logic data_pad_oe_n,
   input wire logic fall_cond_irq,
   input wire logic rise_cond_irq
);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence wr_done_s;
      psel && penable && pready && pwrite;
   endsequence
   sequence release_s;
      wr_done_s ##0 (paddr == ADDR_SAMPLED);
   endsequence
   a_answer_one_cycle: assert property (setup_s |=> pready ##1 !pready)
      else $error("answer not one cycle after setup");
   a_error_with_ready: assert property (pslverr |-> pready)
      else $error("error flag outside answer");
   a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
      else $error("read data not zero when idle");
   a_pads_drive_low: assert property (!clock_pad_out && !data_pad_out)
      else $error("pad drive value not low");
   a_fall_irq_pulse: assert property (fall_cond_irq |=> !fall_cond_irq)
      else $error("fall pulse too long");
   a_rise_irq_pulse: assert property (rise_cond_irq |=> !rise_cond_irq)
      else $error("rise pulse too long");
   a_release_on_write: assert property (release_s |-> ##2 clock_pad_oe_n)
      else $error("clock kept low after release write");
   a_data_pad_cause: assert property ($fell(data_pad_oe_n) |->
      $past(pwrite && pready) || $past(pwrite && pready, 2) || $past(pwrite && pready, 3))
      else $error("data pad taken without a write");
endmodule : bit_assist_props
bind bit_assist bit_assist_props bit_assist_props_i (.*);

// file: verif/serial_peer.sv
// serial peer driving the shared clock and data lines open-drain
`timescale 1ns/1ps
module serial_peer (
   input wire logic clock_line,
   output logic clock_low,
   output logic data_low
);
   initial begin
      clock_low = 1'b0;
      data_low = 1'b0;
   end
   // data moves only while the clock is low, so no condition is made
   task automatic bit_cycle(input logic b);
      #3;
      clock_low = 1'b1;
      #10;
      data_low = !b;
      #30;
      clock_low = 1'b0;
      // a stretched clock stays low until the block lets it go
      wait (clock_line === 1'b1);
      #40;
   endtask : bit_cycle
   task automatic data_edge(input logic b);
      #3;
      data_low = !b;
      #40;
   endtask : data_edge
endmodule : serial_peer

// file: verif/tb.sv
// self-checking bench for the serial bit assist block
`timescale 1ns/1ps
`define chk(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
   $display("mismatch at %0t: got %0h exp %0h", $time, g, e); end end
module tb;
   import bit_assist_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rv;
   logic pready, pslverr, err, clock_pad_out, clock_pad_oe_n, data_pad_out, data_pad_oe_n;
   logic clock_pullup_en, data_pullup_en, fall_cond_irq, rise_cond_irq, irq, ck_low, dt_low;
   logic [7:0] byte_v;
   int mismatches = 0;
   int checks = 0;
   int fall_seen = 0;
   int seed = 32'hf9c2;
   int m_en = 0;
   int m_fall = 0;
   int m_rise = 0;
   int m_new = 0;
   // bench pull-ups: a released line returns high
   wire clock_line = !(clock_pad_oe_n === 1'b0 || ck_low === 1'b1);
   wire data_line = !(data_pad_oe_n === 1'b0 || dt_low === 1'b1);
   bit_assist bit_assist_i (
      .pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .clock_pad_in(clock_line), .clock_pad_out, .clock_pad_oe_n,
      .data_pad_in(data_line), .data_pad_out, .data_pad_oe_n, .clock_pullup_en,
      .data_pullup_en, .fall_cond_irq, .rise_cond_irq, .irq
   );
   serial_peer serial_peer_i (
      .clock_line,
      .clock_low(ck_low),
      .data_low(dt_low)
   );
   initial begin
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      if (fall_cond_irq === 1'b1) fall_seen++;
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_sim
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      `chk(pready, 1'b1)
      rv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      if (a == ADDR_CTRL) m_en = d[0];
      if (a == ADDR_FALL_COND) m_fall = 0;
      if (a == ADDR_RISE_COND) m_rise = 0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `chk(rv, e)
      if (a == ADDR_SAMPLED) m_new = 0;
   endtask : rd
   // synchronised events show some 4-5 cycles after the line moves
   task automatic cyc(input logic b);
      serial_peer_i.bit_cycle(b);
      m_new = 1;
      repeat (8) @(posedge pclk);
   endtask : cyc
   task automatic dedge(input logic b);
      serial_peer_i.data_edge(b);
      if (m_en != 0 && clock_line === 1'b1) begin
         if (b) m_rise = 1;
         else m_fall = 1;
      end
      repeat (8) @(posedge pclk);
   endtask : dedge
   task automatic held(input logic [31:0] c);
      repeat (30) @(posedge pclk);
      `chk(clock_pad_oe_n, 1'b0)
      rd(ADDR_CTRL, c | 32'h8);
      wr(ADDR_SAMPLED, $random(seed));
      @(posedge pclk);
      `chk(clock_pad_oe_n, 1'b1)
      rd(ADDR_CTRL, c);
   endtask : held
   initial begin
      #300000;
      mismatches++;
      end_sim();
   end
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(ADDR_CTRL, 32'h0);
      rd(ADDR_DATA_PAD, 32'h1);
      rd(8'h3C, 32'h0);
      `chk(err, 1'b1)
      wr(ADDR_PULLUP, 32'h30);
      repeat (2) @(posedge pclk);
      `chk({clock_pullup_en, data_pullup_en}, 2'b11)
      dedge(1'b0);
      dedge(1'b1);
      rd(ADDR_FALL_COND, m_fall);
      $display("test idle done");
      wr(ADDR_CTRL, 32'h1);
      dedge(1'b0);
      rd(ADDR_FALL_COND, m_fall);
      `chk(fall_seen, 1)
      rd(ADDR_IRQ_STATUS, 32'h1);
      wr(ADDR_IRQ_ENABLE, 32'h1);
      repeat (2) @(posedge pclk);
      `chk(irq, 1'b1)
      wr(ADDR_IRQ_ENABLE, 32'h0);
      repeat (2) @(posedge pclk);
      `chk(irq, 1'b0)
      wr(ADDR_IRQ_CLEAR, 32'h7);
      rd(ADDR_IRQ_STATUS, 32'h0);
      $display("test conditions done");
      byte_v = 8'($random(seed));
      for (int i = 7; i >= 0; i--) begin
         cyc(byte_v[i]);
         rd(ADDR_NEW_SAMPLE, m_new);
         rd(ADDR_SAMPLED, 32'(byte_v[i]));
         rd(ADDR_NEW_SAMPLE, m_new);
      end
      cyc(1'b0);
      dedge(1'b1);
      rd(ADDR_RISE_COND, m_rise);
      wr(ADDR_FALL_COND, $random(seed));
      wr(ADDR_RISE_COND, $random(seed));
      rd(ADDR_FALL_COND, 32'h0);
      rd(ADDR_RISE_COND, 32'h0);
      $display("test sampling done");
      wr(ADDR_DATA_PAD, 32'h0);
      repeat (8) @(posedge pclk);
      rd(ADDR_DATA_PAD, 32'h0);
      wr(ADDR_DATA_PAD, 32'h1);
      serial_peer_i.clock_low <= 1'b1;
      repeat (8) @(posedge pclk);
      rd(ADDR_CLOCK_PAD, 32'h0);
      serial_peer_i.clock_low <= 1'b0;
      $display("test pads done");
      wr(ADDR_CTRL, 32'h3);
      fork
         cyc(1'b1);
         held(32'h3);
      join
      wr(ADDR_CTRL, 32'h5);
      wr(ADDR_FALL_COND, 32'h0);
      cyc(1'b1);
      `chk(clock_pad_oe_n, 1'b1)
      dedge(1'b0);
      fork
         cyc(1'b0);
         held(32'h5);
      join
      $display("test stretching done");
      end_sim();
   end
endmodule : tb
